/* File: shared/uei_pkg.sv */
// Package with register map and field layout for the endpoint irq summary
package uei_pkg;
    localparam int          NUM_EP       = 7;
    localparam int          NUM_SRC      = 5;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 8;
    localparam logic [7:0]  ADDR_IRQ_EN  = 8'hC2;
    localparam logic [7:0]  ADDR_FLAGS   = 8'hF8;
    localparam logic [7:0]  RESET_EN     = 8'h00;
    localparam logic [7:0]  READ_ZERO    = 8'h00;
    localparam int          SRC_TRANSMIT_COMPLETE    = 0;
    localparam int          SRC_RXB0     = 1;
    localparam int          SRC_RXB1     = 2;
    localparam int          SRC_SETUP    = 3;
    localparam int          SRC_STALL_OR_CRC_ERROR   = 4;

    typedef struct packed {
        logic                stall_or_crc_error;
        logic                setup_received;
        logic                rx_out_bank_one;
        logic                rx_out_bank_zero;
        logic                transmit_complete;
    } uei_src_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                wr;
        logic                rd;
    } uei_bus_t;
endpackage

/* File: hdl/uei_summary.sv */
// Endpoint interrupt summary flags, enables and shared USB interrupt
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module uei_summary
(
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    input  wire uei_pkg::uei_bus_t             bus,
    input  wire uei_pkg::uei_src_t [6:0]       ep_src,
    output var  logic [uei_pkg::DATA_W-1:0]    rdata,
    output var  logic                          usb_irq
);
    import uei_pkg::*;

    logic [NUM_EP-1:0] flags_r;
    logic [NUM_EP-1:0] flags_nxt;
    logic [NUM_EP-1:0] enable_r;
    logic [NUM_EP-1:0] src_any;
    logic [NUM_EP-1:0] pend_nxt;
    logic              irq_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic              en_wr_hit;
    logic              en_rd_hit;
    logic              flag_wr_hit;
    logic              flag_rd_hit;

    // Sources come from same-clock status logic, so no synchroniser
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            assign src_any[g] = |ep_src[g];
        end
    endgenerate

    // Level follow: flag is a registered OR, so set and clear never race
    always_comb
    begin
        flags_nxt = src_any;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            flags_r <= '0;
        else
            flags_r <= flags_nxt;
    end

    // Exact address match; a partial decode would alias stray writes
    always_comb
    begin
        en_wr_hit   = bus.wr && (bus.addr == ADDR_IRQ_EN);
        en_rd_hit   = bus.rd && (bus.addr == ADDR_IRQ_EN);
        flag_wr_hit = bus.wr && (bus.addr == ADDR_FLAGS);
        flag_rd_hit = bus.rd && (bus.addr == ADDR_FLAGS);
    end

    // Bit 7 of the write data is dropped, so it never reads back as one
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            enable_r <= RESET_EN[NUM_EP-1:0];
        else if (en_wr_hit)
            enable_r <= bus.wdata[NUM_EP-1:0];
    end

    always_comb
    begin
        pend_nxt = flags_r & enable_r;
        irq_nxt  = |pend_nxt;
    end

    // Interrupt follows the flags one cycle late; kept registered for timing
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            usb_irq <= 1'b0;
        else
            usb_irq <= irq_nxt;
    end

    // Writes to the flag address fall through: no effect
    always_comb
    begin
        rdata_nxt = READ_ZERO;
        if (en_rd_hit)
            rdata_nxt = {1'b0, enable_r};
        else if (flag_rd_hit)
            rdata_nxt = {1'b0, flags_r};
    end

    // Read data stands one cycle only, then drops back to zero
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= READ_ZERO;
        else
            rdata <= rdata_nxt;
    end

    a_flag_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        flags_r == $past(src_any))
        else $error("flag does not follow sources");

    a_flag_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        (src_any == '0) |=> (flags_r == '0))
        else $error("flag not cleared");

    a_src_or: assert property (@(posedge core_clk) disable iff (!rstn)
        ep_src[0].setup_received |=> flags_r[0])
        else $error("setup source missed");

    sequence s_pending;
        |(flags_r & enable_r);
    endsequence

    a_irq_raise: assert property (@(posedge core_clk) disable iff (!rstn)
        s_pending |=> usb_irq)
        else $error("irq not raised");

    a_irq_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        !(|(flags_r & enable_r)) |=> !usb_irq)
        else $error("irq without cause");

    a_en_write: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus.wr && bus.addr == ADDR_IRQ_EN) |=>
        enable_r == $past(bus.wdata[NUM_EP-1:0]))
        else $error("enable write lost");

    a_bit7_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        rdata[DATA_W-1] == 1'b0)
        else $error("bit 7 reads one");

    a_flags_ro: assert property (@(posedge core_clk) disable iff (!rstn)
        flag_wr_hit |=>
        ($stable(enable_r) && flags_r == $past(src_any)))
        else $error("flag write took effect");

    a_read_flags: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus.rd && bus.addr == ADDR_FLAGS) |=>
        rdata == {1'b0, $past(flags_r)})
        else $error("flag readback wrong");

    sequence s_en_read;
        en_rd_hit;
    endsequence

    a_read_en: assert property (@(posedge core_clk) disable iff (!rstn)
        s_en_read |=> rdata == {1'b0, $past(enable_r)})
        else $error("enable readback wrong");

    a_read_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !(en_rd_hit || flag_rd_hit) |=> rdata == READ_ZERO)
        else $error("read data without a read");

    a_wr_no_data: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus.wr && !bus.rd) |=> rdata == READ_ZERO)
        else $error("write produced read data");

    a_en_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !en_wr_hit |=> $stable(enable_r))
        else $error("enable changed without a write");

    a_irq_masked: assert property (@(posedge core_clk) disable iff (!rstn)
        (enable_r == '0) |=> !usb_irq)
        else $error("irq while all endpoints masked");

    a_irq_cause: assert property (@(posedge core_clk) disable iff (!rstn)
        usb_irq |-> ($past(flags_r & enable_r) != '0))
        else $error("irq raised with nothing pending");

    sequence s_src_up;
        (src_any & enable_r) != '0;
    endsequence

    a_src_to_irq: assert property (@(posedge core_clk) disable iff (!rstn)
        s_src_up ##1 s_pending |=> usb_irq)
        else $error("source did not reach irq");

    sequence s_all_quiet;
        src_any == '0;
    endsequence

    sequence s_flags_gone;
        flags_r == '0;
    endsequence

    a_quiet_chain: assert property (@(posedge core_clk) disable iff (!rstn)
        s_all_quiet |=> s_flags_gone ##1 !usb_irq)
        else $error("irq outlived its sources");

    // Per endpoint and per source, so one dead OR input shows up
    genvar s;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep_chk
            a_ep_set: assert property (@(posedge core_clk) disable iff (!rstn)
                src_any[g] |=> flags_r[g])
                else $error("endpoint flag not set");

            a_ep_clear: assert property (@(posedge core_clk)
                disable iff (!rstn) !src_any[g] |=> !flags_r[g])
                else $error("endpoint flag not cleared");

            for (s = 0; s < NUM_SRC; s++)
            begin : g_src_chk
                a_src_each: assert property (@(posedge core_clk)
                    disable iff (!rstn) ep_src[g][s] |=> flags_r[g])
                    else $error("endpoint source ignored");
            end
        end
    endgenerate
endmodule // uei_summary
`default_nettype wire

/* File: verification/uei_src_model.sv */
// Endpoint status source model for the summary bench
`timescale 1ns/100ps
`default_nettype none
module uei_src_model
(
    output var uei_pkg::uei_src_t [6:0] ep_src
);
    import uei_pkg::*;
    initial ep_src = '0;
    // Called on an edge only, so levels move as status logic would
    task automatic put(input int ep, input logic [4:0] v);
        ep_src[ep] <= v;
    endtask
endmodule // uei_src_model
`default_nettype wire

/* File: verification/tb_uei_summary.sv */
// Self-checking bench for the endpoint irq summary
`timescale 1ns/100ps
`default_nettype none
module tb_uei_summary;
    import uei_pkg::*;
    logic           core_clk = 0;
    logic           rstn = 0;
    logic           usb_irq;
    logic [7:0]     rdata;
    uei_bus_t       bus = '0;
    uei_src_t [6:0] ep_src;
    int             miscompares = 0, checked = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    uei_summary DUT (.core_clk(core_clk), .rstn(rstn), .bus(bus),
        .ep_src(ep_src), .rdata(rdata), .usb_irq(usb_irq));
    uei_src_model SRC (.ep_src(ep_src));
    task automatic chk(input string n, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Extra idle cycle keeps one assignment per time step
    task automatic wr(input logic [7:0] a, d);
        bus <= '{a, d, 1'b1, 1'b0};
        tick(1);
        bus <= '0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, exp);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        bus <= '0;
        #1 chk("rdata", rdata, exp);
        tick(1);
    endtask
    task automatic see(input logic e);
        #1 chk("usb_irq", {7'h00, usb_irq}, {7'h00, e});
        tick(1);
    endtask
    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        tick(20);
        rstn <= 1'b1;
        tick(1);
        rd(ADDR_IRQ_EN, RESET_EN);
        rd(8'h00, READ_ZERO);
        for (int e = 0; e < NUM_EP; e++)
            for (int s = 0; s < NUM_SRC; s++)
            begin
                SRC.put(e, 5'(1 << s));
                tick(1);
                rd(ADDR_FLAGS, 8'(1 << e));
                SRC.put(e, 5'h00);
                tick(1);
                rd(ADDR_FLAGS, 8'h00);
            end
        $display("flag test done");
        wr(ADDR_IRQ_EN, 8'h7F);
        rd(ADDR_IRQ_EN, 8'h7F);
        for (int e = 0; e < NUM_EP; e++)
        begin
            wr(ADDR_IRQ_EN, 8'(1 << e));
            SRC.put((e + 1) % NUM_EP, 5'h10);
            tick(2);
            see(1'b0);
            SRC.put(e, 5'h08);
            tick(2);
            see(1'b1);
            wr(ADDR_FLAGS, 8'h00);
            rd(ADDR_FLAGS, 8'(1 << e | 1 << ((e + 1) % NUM_EP)));
            rd(ADDR_IRQ_EN, 8'(1 << e));
            SRC.put(e, 5'h00);
            SRC.put((e + 1) % NUM_EP, 5'h00);
            tick(2);
            see(1'b0);
        end
        $display("irq test done");
        final_report();
    end
endmodule // tb_uei_summary
`default_nettype wire
